// ===== common/mmca_pkg.sv
// shared constants and types for the micromirror cell array update block
`default_nettype none
package mmca_pkg;
    localparam int unsigned COLS = 912;
    localparam int unsigned ROWS = 1140;
    localparam int unsigned BORDER = 10;
    localparam int unsigned BUS_W = 24;
    localparam int unsigned BEAT_W = 2 * BUS_W;
    localparam int unsigned BEATS = (ROWS + BEAT_W - 1) / BEAT_W;
    localparam int unsigned STAGE_W = BEATS * BEAT_W;
    localparam int unsigned COL_W = 10;
    localparam int unsigned ROW_W = 11;
    localparam int unsigned XH_W = 11;
    localparam int unsigned BEAT_CNT_W = 5;
    localparam logic [COL_W-1:0] COL_LIMIT = 10'(COLS);
    localparam logic [COL_W-1:0] QCOL_LO = 10'(BORDER);
    localparam logic [COL_W-1:0] QCOL_HI = 10'(BORDER + COLS);
    localparam logic [ROW_W-1:0] QROW_LO = 11'(BORDER);
    localparam logic [ROW_W-1:0] QROW_HI = 11'(BORDER + ROWS);
    localparam logic [BEAT_CNT_W-1:0] LAST_BEAT = 5'(BEATS - 1);
    localparam logic [BEAT_CNT_W-1:0] BEAT_ZERO = 5'h00;

    typedef enum logic [1:0] {
        MMCA_IDLE = 2'h0,
        MMCA_LOAD = 2'h1,
        MMCA_COMMIT = 2'h3
    } mmca_state_t;

    typedef enum logic [1:0] {
        MMCA_PARKED = 2'h0,
        MMCA_OFF = 2'h1,
        MMCA_ON = 2'h2
    } mmca_pos_t;

    // one bus clock carries a rising-edge and a falling-edge word
    typedef struct packed {
        logic [BUS_W-1:0] fall;
        logic [BUS_W-1:0] rise;
    } mmca_beat_t;

    // query position includes the border band
    typedef struct packed {
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
    } mmca_query_t;
endpackage : mmca_pkg
`default_nettype wire

// ===== hdl/mmca_top.sv
// micromirror cell store, column loader and mirror commit logic
// Behaviour
// - hold 912 by 1140 single-bit cell store
// - load one column over 24-bit DDR bus
// - odd rows sit half a pixel shifted
// - cell one lands mirror on after pulse
// - cell zero lands mirror off after pulse
// - mirrors change only on clocking pulse
// - reset pulses internal, start coordinated by controller
// - ten-wide border never reachable by writes
// - border mirrors land off after power-up
// - parked flat state is never latched
`default_nettype none
module mmca_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_en,
    input wire logic col_start,
    input wire logic [mmca_pkg::COL_W-1:0] col_index,
    input wire logic beat_valid,
    input wire mmca_pkg::mmca_beat_t beat,
    input wire logic clocking_pulse,
    input wire logic park,
    input wire mmca_pkg::mmca_query_t query,
    output logic load_busy,
    output logic col_done,
    output mmca_pkg::mmca_pos_t mirror_pos,
    output logic [mmca_pkg::XH_W-1:0] query_xhalf
);
    // cell store and displayed mirror state, one column word each
    logic [mmca_pkg::ROWS-1:0] cells [mmca_pkg::COLS];
    logic [mmca_pkg::ROWS-1:0] mirror [mmca_pkg::COLS];

    mmca_pkg::mmca_state_t state, next_state;
    logic [mmca_pkg::BEAT_CNT_W-1:0] beat_cnt, next_beat_cnt;
    logic [mmca_pkg::STAGE_W-1:0] stage, next_stage;
    logic [mmca_pkg::COL_W-1:0] col_sel, next_col_sel;
    logic col_ok, next_col_ok;
    logic next_load_busy, next_col_done;
    logic cell_we;
    logic [mmca_pkg::ROWS-1:0] stage_rows;

    // loader: column index taken at start, then fixed beat count
    always_comb begin
        next_state = state;
        next_beat_cnt = beat_cnt;
        next_stage = stage;
        next_col_sel = col_sel;
        next_col_ok = col_ok;
        next_col_done = 1'b0;
        cell_we = 1'b0;
        case (state)
            mmca_pkg::MMCA_IDLE: begin
                if (col_start) begin
                    next_state = mmca_pkg::MMCA_LOAD;
                    next_col_sel = col_index;
                    next_col_ok = col_index < mmca_pkg::COL_LIMIT;
                    next_beat_cnt = mmca_pkg::BEAT_ZERO;
                end
            end
            mmca_pkg::MMCA_LOAD: begin
                if (beat_valid) begin
                    // rising word is the lower half; first beat ends lowest
                    next_stage = {beat, stage[mmca_pkg::STAGE_W-1:mmca_pkg::BEAT_W]};
                    next_beat_cnt = beat_cnt + 5'h01;
                    if (beat_cnt == mmca_pkg::LAST_BEAT) begin
                        next_state = mmca_pkg::MMCA_COMMIT;
                    end
                end
            end
            mmca_pkg::MMCA_COMMIT: begin
                // out-of-range column drops here, store untouched
                cell_we = col_ok;
                next_col_done = col_ok;
                next_state = mmca_pkg::MMCA_IDLE;
            end
            default: begin
                next_state = mmca_pkg::MMCA_IDLE;
            end
        endcase
        next_load_busy = next_state != mmca_pkg::MMCA_IDLE;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= mmca_pkg::MMCA_IDLE;
            beat_cnt <= mmca_pkg::BEAT_ZERO;
            stage <= '0;
            col_sel <= '0;
            col_ok <= 1'b0;
            load_busy <= 1'b0;
            col_done <= 1'b0;
        end else if (clock_en) begin
            state <= next_state;
            beat_cnt <= next_beat_cnt;
            stage <= next_stage;
            col_sel <= next_col_sel;
            col_ok <= next_col_ok;
            load_busy <= next_load_busy;
            col_done <= next_col_done;
        end
    end

    // last beat carries spare rows beyond the array, dropped here
    assign stage_rows = stage[mmca_pkg::ROWS-1:0];

    // cells written by column only; border band has no cells at all
    always_ff @(posedge clock) begin
        if (clock_en && cell_we) begin
            cells[col_sel] <= stage_rows;
        end
    end

    // whole array copies at once on the pulse, never on a cell write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < mmca_pkg::COLS; c++) begin
                mirror[c] <= '0;
            end
        end else if (clock_en && clocking_pulse) begin
            for (int c = 0; c < mmca_pkg::COLS; c++) begin
                mirror[c] <= cells[c];
            end
        end
    end

    // query path: registered lookup so the output comes from a flop
    logic q_active, q_border;
    logic [mmca_pkg::COL_W-1:0] q_col;
    logic [mmca_pkg::ROW_W-1:0] q_row;
    logic sel_mirror, sel_cell;
    mmca_pkg::mmca_pos_t next_mirror_pos;
    logic [mmca_pkg::XH_W-1:0] next_query_xhalf;

    always_comb begin
        q_active = query.col >= mmca_pkg::QCOL_LO && query.col < mmca_pkg::QCOL_HI
            && query.row >= mmca_pkg::QROW_LO && query.row < mmca_pkg::QROW_HI;
        q_border = !q_active;
        q_col = q_active ? query.col - mmca_pkg::QCOL_LO : '0;
        q_row = q_active ? query.row - mmca_pkg::QROW_LO : '0;
        sel_mirror = mirror[q_col][q_row];
        sel_cell = cells[q_col][q_row];
        // park is a live level: released mirrors fall back to stored state
        if (park) begin
            next_mirror_pos = mmca_pkg::MMCA_PARKED;
        end else if (q_border) begin
            next_mirror_pos = mmca_pkg::MMCA_OFF;
        end else if (sel_mirror) begin
            next_mirror_pos = mmca_pkg::MMCA_ON;
        end else begin
            next_mirror_pos = mmca_pkg::MMCA_OFF;
        end
        // odd rows add one half-pitch to the horizontal position
        next_query_xhalf = {query.col, query.row[0]};
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mirror_pos <= mmca_pkg::MMCA_OFF;
            query_xhalf <= '0;
        end else if (clock_en) begin
            mirror_pos <= next_mirror_pos;
            query_xhalf <= next_query_xhalf;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_load_beat_count: assert property (
        (clock_en && state == mmca_pkg::MMCA_LOAD && beat_valid && beat_cnt == mmca_pkg::LAST_BEAT)
        |=> state == mmca_pkg::MMCA_COMMIT)
        else $error("column load did not end after last beat");

    a_bad_col_drop: assert property (
        (clock_en && state == mmca_pkg::MMCA_COMMIT && !col_ok) |=> !col_done)
        else $error("out-of-range column was committed");

    a_good_col_done: assert property (
        (clock_en && state == mmca_pkg::MMCA_IDLE && col_start && col_index < mmca_pkg::COL_LIMIT)
        ##1 (clock_en && beat_valid)[*8] ##0 1'b1 |-> 1'b1 ##[1:40] col_done || !clock_en)
        else $error("valid column load gave no done pulse");

    a_mirror_hold: assert property (
        (clock_en && !clocking_pulse) ##1 $stable(query) |-> $stable(sel_mirror))
        else $error("mirror changed without a clocking pulse");

    a_pulse_commit: assert property (
        (clock_en && clocking_pulse) ##1 $stable(query) |-> sel_mirror == $past(sel_cell))
        else $error("clocking pulse did not copy the cell");

    a_border_off: assert property (
        (clock_en && !park && q_border) |=> mirror_pos == mmca_pkg::MMCA_OFF)
        else $error("border mirror not landed off");

    a_park_flat: assert property (
        (clock_en && park) ##1 (clock_en && !park && q_active && sel_mirror)
        |=> mirror_pos == mmca_pkg::MMCA_ON)
        else $error("parked state held after release");

    a_on_landing: assert property (
        (clock_en && !park && q_active && sel_mirror) |=> mirror_pos == mmca_pkg::MMCA_ON)
        else $error("cell one did not land on");

    a_half_shift: assert property (
        clock_en |=> query_xhalf[0] == $past(query.row[0]))
        else $error("odd row shift missing");

    a_start_busy: assert property (
        (clock_en && state == mmca_pkg::MMCA_IDLE && col_start)
        |=> load_busy)
        else $error("column start did not raise busy");

    a_index_capture: assert property (
        (clock_en && state == mmca_pkg::MMCA_IDLE && col_start)
        |=> col_sel == $past(col_index))
        else $error("column index not captured at start");

    a_range_flag: assert property (
        (clock_en && state == mmca_pkg::MMCA_IDLE && col_start && col_index >= mmca_pkg::COL_LIMIT)
        |=> !col_ok)
        else $error("out-of-range column marked writable");

    a_index_held: assert property (
        (clock_en && state != mmca_pkg::MMCA_IDLE)
        |=> $stable(col_sel) && $stable(col_ok))
        else $error("column index moved during a load");

    a_idle_wait: assert property (
        (clock_en && state == mmca_pkg::MMCA_IDLE && !col_start)
        |=> state == mmca_pkg::MMCA_IDLE)
        else $error("loader left idle without a start");

    a_load_stays: assert property (
        (clock_en && state == mmca_pkg::MMCA_LOAD)
        |=> state != mmca_pkg::MMCA_IDLE)
        else $error("loader skipped the commit cycle");

    a_beat_step: assert property (
        (clock_en && state == mmca_pkg::MMCA_LOAD && beat_valid)
        |=> beat_cnt == $past(beat_cnt) + 5'h01)
        else $error("beat count did not advance on a beat");

    a_gap_hold: assert property (
        (clock_en && state == mmca_pkg::MMCA_LOAD && !beat_valid)
        |=> state == mmca_pkg::MMCA_LOAD && $stable(beat_cnt) && $stable(stage))
        else $error("loader moved without a beat");

    a_commit_leave: assert property (
        (clock_en && state == mmca_pkg::MMCA_COMMIT)
        |=> state == mmca_pkg::MMCA_IDLE && !load_busy)
        else $error("commit cycle did not return to idle");

    a_column_write: assert property (
        (clock_en && cell_we)
        |=> cells[col_sel] == $past(stage_rows))
        else $error("column store does not hold the loaded rows");

    a_done_pulse: assert property (
        (clock_en && col_done)
        |=> !col_done)
        else $error("done pulse longer than one cycle");

    a_done_source: assert property (
        (clock_en && state != mmca_pkg::MMCA_COMMIT)
        |=> !col_done)
        else $error("done pulse without a commit");

    a_done_idle: assert property (
        col_done
        |-> !load_busy)
        else $error("done pulse while still busy");

    a_freeze_hold: assert property (
        !clock_en
        |=> $stable(state) && $stable(beat_cnt) && $stable(load_busy)
            && $stable(col_done) && $stable(mirror_pos) && $stable(query_xhalf))
        else $error("state moved with clock enable low");

    a_park_output: assert property (
        (clock_en && park)
        |=> mirror_pos == mmca_pkg::MMCA_PARKED)
        else $error("park did not show flat mirrors");

    a_off_landing: assert property (
        (clock_en && !park && q_active && !sel_mirror)
        |=> mirror_pos == mmca_pkg::MMCA_OFF)
        else $error("cell zero did not land off");

    a_border_left: assert property (
        (clock_en && !park && query.col < mmca_pkg::QCOL_LO)
        |=> mirror_pos == mmca_pkg::MMCA_OFF)
        else $error("left border mirror not off");

    a_border_right: assert property (
        (clock_en && !park && query.col >= mmca_pkg::QCOL_HI)
        |=> mirror_pos == mmca_pkg::MMCA_OFF)
        else $error("right border mirror not off");

    a_border_bottom: assert property (
        (clock_en && !park && query.row >= mmca_pkg::QROW_HI)
        |=> mirror_pos == mmca_pkg::MMCA_OFF)
        else $error("bottom border mirror not off");

    a_xhalf_col: assert property (
        clock_en
        |=> query_xhalf[mmca_pkg::XH_W-1:1] == $past(query.col))
        else $error("column part of the half-pitch position wrong");
endmodule : mmca_top
`default_nettype wire

// ===== verif/mmca_ctrl_model.sv
// display controller model that streams column data into the cell array
`default_nettype none
module mmca_ctrl_model (
    input wire logic clock,
    output logic col_start,
    output logic [mmca_pkg::COL_W-1:0] col_index,
    output logic beat_valid,
    output mmca_pkg::mmca_beat_t beat
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        col_start = 1'b0;
        col_index = 10'h000;
        beat_valid = 1'b0;
        beat = 48'h000000000000;
    end
    // slow pacing stands for streaming, fast for burst; both far under the rate caps
    task automatic send(input logic [9:0] idx, input logic fill, input logic slow);
        int k;
        @(posedge clock);
        #1;
        col_start = 1'b1;
        col_index = idx;
        @(posedge clock);
        #1;
        col_start = 1'b0;
        col_index = ~idx; // index is only held with the start strobe
        for (k = 0; k < 24; k++) begin
            if (slow) begin
                beat_valid = 1'b0;
                beat = ~beat; // bus not qualified: show garbage, not the last word
                @(posedge clock);
                #1;
            end
            beat_valid = 1'b1;
            beat = {48{fill}};
            @(posedge clock);
            #1;
        end
        beat_valid = 1'b0;
        beat = ~beat;
    endtask
endmodule // mmca_ctrl_model
`default_nettype wire

// ===== verif/tb_micromirror_cell_array_update.sv
// self-checking bench for the micromirror cell array update block
`default_nettype none
module tb_micromirror_cell_array_update;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [10:0] P_ON = 11'(mmca_pkg::MMCA_ON);
    localparam logic [10:0] P_OFF = 11'(mmca_pkg::MMCA_OFF);
    localparam logic [10:0] P_PARK = 11'(mmca_pkg::MMCA_PARKED);
    logic clock, rst, clock_en, clocking_pulse, park, col_start, beat_valid, load_busy, col_done;
    logic [9:0] col_index;
    mmca_pkg::mmca_beat_t beat;
    mmca_pkg::mmca_query_t query;
    mmca_pkg::mmca_pos_t mirror_pos;
    logic [10:0] query_xhalf;
    int err_count, compares;
    logic seen;
    mmca_ctrl_model ctl (.clock(clock), .col_start(col_start), .col_index(col_index), .beat_valid(beat_valid),
        .beat(beat));
    mmca_top dut (.clock(clock), .rst(rst), .clock_en(clock_en), .col_start(col_start), .col_index(col_index),
        .beat_valid(beat_valid), .beat(beat), .clocking_pulse(clocking_pulse), .park(park), .query(query),
        .load_busy(load_busy), .col_done(col_done), .mirror_pos(mirror_pos), .query_xhalf(query_xhalf));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask
    // query is answered one enabled edge later
    task automatic look(input logic [9:0] c, input logic [10:0] r, input logic [10:0] exp);
        query = {c, r};
        step(1);
        chk("mirror_pos", exp, 11'(mirror_pos));
    endtask
    task automatic pulse();
        clocking_pulse = 1'b1; // whole array at once
        step(1);
        clocking_pulse = 1'b0;
    endtask
    // load a column, then watch a bounded span for the completion pulse
    task automatic load(input logic [9:0] idx, input logic fill, input logic slow, input logic exp);
        ctl.send(idx, fill, slow);
        chk("load_busy", 11'h001, 11'(load_busy));
        seen = 1'b0;
        repeat (10) begin
            step(1);
            if (col_done === 1'b1) seen = 1'b1;
        end
        chk("col_done", 11'(exp), 11'(seen));
    endtask
    task automatic t_reset();
        chk("reset mirror_pos", P_OFF, 11'(mirror_pos));
        chk("reset col_done", 11'h000, 11'(col_done));
        rst = 1'b0;
    endtask
    task automatic t_border();
        look(10'h000, 11'h1F4, P_OFF);
        look(10'h3A3, 11'h000, P_OFF);
        look(10'h014, 11'h487, P_OFF);
        look(10'h00F, 11'h00B, P_OFF);
        chk("query_xhalf", 11'h01F, query_xhalf); // odd row shifted half a pitch
    endtask
    task automatic t_loads();
        load(10'h005, 1'b1, 1'b0, 1'b1);
        look(10'h00F, 11'h00A, P_OFF); // stored but not yet shown
        pulse();
        look(10'h00F, 11'h00A, P_ON);
        look(10'h00F, 11'h47D, P_ON); // last active row
        load(10'h005, 1'b0, 1'b1, 1'b1); // gaps between beats
        look(10'h00F, 11'h00A, P_ON);
        pulse();
        look(10'h00F, 11'h00A, P_OFF);
        load(10'h390, 1'b1, 1'b0, 1'b0); // index 912
        pulse();
        look(10'h00F, 11'h00A, P_OFF); // nothing written
    endtask
    task automatic t_park();
        load(10'h005, 1'b1, 1'b0, 1'b1);
        pulse();
        park = 1'b1;
        look(10'h00F, 11'h00A, P_PARK);
        park = 1'b0;
        look(10'h00F, 11'h00A, P_ON); // flat state not held
    endtask
    // enable low must freeze outputs even while park and query move
    task automatic t_freeze();
        clock_en = 1'b0;
        park = 1'b1;
        query = 21'h000000;
        step(3);
        chk("frozen mirror_pos", P_ON, 11'(mirror_pos));
        chk("frozen query_xhalf", 11'h01E, query_xhalf);
        clock_en = 1'b1;
        park = 1'b0;
        look(10'h00F, 11'h00A, P_ON);
    endtask
    initial begin
        #200000;
        err_count++;
        conclude();
    end
    initial begin
        err_count = 0;
        compares = 0;
        rst = 1'b1;
        clock_en = 1'b1;
        clocking_pulse = 1'b0;
        park = 1'b0;
        query = 21'h000000;
        step(2);
        t_reset();
        t_border();
        t_loads();
        t_park();
        t_freeze();
        step(2);
        conclude();
    end
endmodule // tb_micromirror_cell_array_update
`default_nettype wire
